//--- hw/sss_regs.svh
// sss_regs.svh: register offsets, field positions, reset values
// assumes: included by bare name; byte addresses on a 32-bit bus
// Behaviour
// - slave when clocked, enabled, strobe external
// - nine-bit select makes receive words nine bits
// - ninth received bit readable in status
// - continuous receive enable gates slave reception
// - completed word sets receive flag, interrupt
// - data read returns oldest word, pops
// - overrun cleared by receive or port disable
// - only slave mode keeps shifting in sleep
// - shifters advance only on external strobe
// - receive flag clears once buffer empty
// - word received in sleep sets flag, wakes
// - vectoring needs global and peripheral enables
// - wake continues; vector taken with global
// - transmit write clears flag, fills shifter
// - transmit data shifted out on strobe
// - shifter empty reloads buffer, sets flag
// - further transmit write clears flag again
// - transmit wake needs transmit, peripheral enables
// - single receive enable ignored by slave reception
// - both receive enables clear means transmit
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH
// byte offsets
`define SSS_A_RCS 8'h00
`define SSS_A_RXD 8'h04
`define SSS_A_TCS 8'h08
`define SSS_A_RATE 8'h0C
`define SSS_A_TXD 8'h10
`define SSS_A_IEN 8'h14
// receive control/status fields
`define SSS_B_PORT_EN 7
`define SSS_B_NINE_RX 6
`define SSS_B_SINGLE_RX 5
`define SSS_B_CONT_RX 4
`define SSS_B_OVERRUN 1
`define SSS_B_NINTH_RX 0
// transmit control/status fields
`define SSS_B_CLK_SRC 7
`define SSS_B_NINE_TX 6
`define SSS_B_TX_EN 5
`define SSS_B_CLOCKED 4
`define SSS_B_SH_EMPTY 1
`define SSS_B_NINTH_TX 0
// rate control fields
`define SSS_B_RX_IDLE 6
`define SSS_B_INVERT 4
// interrupt enable/status fields
`define SSS_B_GLOBAL_IE 7
`define SSS_B_PERIPH_IE 6
`define SSS_B_RX_IE 5
`define SSS_B_TX_IE 4
`define SSS_B_RX_DONE 1
`define SSS_B_TX_FREE 0
// reset values and constants
`define SSS_RST_RXCFG 4'h0
`define SSS_RST_TXCFG 5'h00
`define SSS_RST_IEN 4'h0
`define SSS_VECTOR 16'h0004
`define SSS_FIFO_DEPTH 2
`endif

//--- hw/sss_pkg.sv
// sss_pkg: types shared by the serial slave port
// assumes: sss_regs.svh holds all numbers
package sss_pkg;
	typedef struct packed {
		logic port_en;
		logic nine_rx;
		logic single_rx;
		logic cont_rx;
	} sss_rxcfg_t;
	typedef struct packed {
		logic clk_src;
		logic nine_tx;
		logic tx_en;
		logic clocked;
		logic ninth_tx;
	} sss_txcfg_t;
	typedef struct packed {
		logic global_ie;
		logic periph_ie;
		logic rx_ie;
		logic tx_ie;
	} sss_ien_t;
	typedef struct packed {
		logic [7:0]  adr;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] dat;
	} sss_wbreq_t;
	typedef enum logic {TXS_IDLE, TXS_SHIFT} sss_txst_t;
endpackage

//--- hw/sss_slave_port.sv
// sss_slave_port: synchronous slave serial port with wishbone registers
// assumes: strobe and line pins are asynchronous to clk and much slower
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
`include "sss_regs.svh"
module sss_slave_port #(
	parameter int DEPTH = `SSS_FIFO_DEPTH
) (
	// system
	input  wire logic        clk,
	input  wire logic        rst_n,
	// wishbone classic slave
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_wr,
	output logic      [31:0] wb_dat_rd,
	output logic             wb_ack,
	// processor state
	input  wire logic        cpu_sleep,
	// serial pins
	input  wire logic        serial_strobe_pin,
	input  wire logic        serial_line_pin_in,
	output logic             serial_line_pin_out,
	output logic             serial_line_pin_oe,
	// wake and interrupt
	output logic             wake_req,
	output logic             irq_req,
	output logic             vector_take,
	output logic      [15:0] vector_addr
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	function automatic logic [7:0] fld(input logic b, input int p);
		fld = 8'(b) << p;
	endfunction

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////
	// state

	sss_pkg::sss_rxcfg_t rxcfg_reg;
	sss_pkg::sss_txcfg_t txcfg_reg;
	sss_pkg::sss_ien_t   ien_reg;
	sss_pkg::sss_txst_t  tx_st_reg;
	logic        invert_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic [1:0]  strb_sync_reg;
	logic [1:0]  line_sync_reg;
	logic        strb_last_reg;
	logic [8:0]  rsh_reg;
	logic [3:0]  rcnt_reg;
	logic [8:0]  fifo_mem [DEPTH];
	logic [AW-1:0] rd_ptr_reg;
	logic [AW-1:0] wr_ptr_reg;
	logic [AW:0] cnt_reg;
	logic        ovr_reg;
	logic [8:0]  tbuf_reg;
	logic        tbuf_full_reg;
	logic [8:0]  tsh_reg;
	logic [3:0]  tcnt_reg;
	logic        oe_reg;

	////////////////////////////////////////////////////////////////
	// bus decode: one wait state, ack drops the cycle after

	sss_pkg::sss_wbreq_t req;
	assign req = '{adr: wb_adr, we: wb_we, sel: wb_sel, dat: wb_dat_wr};

	wire logic acc    = wb_cyc & wb_stb & ~ack_reg;
	wire logic wr     = acc & req.we & req.sel[0];
	wire logic rd     = acc & ~req.we;
	wire logic wr_rcs = wr & hit(req.adr, `SSS_A_RCS);
	wire logic wr_tcs = wr & hit(req.adr, `SSS_A_TCS);
	wire logic wr_rate = wr & hit(req.adr, `SSS_A_RATE);
	wire logic wr_txd = wr & hit(req.adr, `SSS_A_TXD);
	wire logic wr_ien = wr & hit(req.adr, `SSS_A_IEN);
	wire logic rd_rxd = rd & hit(req.adr, `SSS_A_RXD);

	assign wb_ack    = ack_reg;
	assign wb_dat_rd = dat_reg;

	////////////////////////////////////////////////////////////////
	// mode decode

	// slave needs clocked mode, port on, strobe from outside
	wire logic slave_mode = txcfg_reg.clocked & rxcfg_reg.port_en
		& ~txcfg_reg.clk_src;
	// either receive enable selects receive direction
	wire logic rx_mode = rxcfg_reg.single_rx | rxcfg_reg.cont_rx;
	// single receive plays no part in accepting words
	wire logic rx_run = slave_mode & rxcfg_reg.cont_rx;
	wire logic tx_run = slave_mode & ~rx_mode & txcfg_reg.tx_en;
	wire logic port_clr = ~rxcfg_reg.port_en;

	////////////////////////////////////////////////////////////////
	// config registers

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxcfg_reg  <= `SSS_RST_RXCFG;
			txcfg_reg  <= `SSS_RST_TXCFG;
			ien_reg    <= `SSS_RST_IEN;
			invert_reg <= 1'b0;
		end else begin
			if (wr_rcs) begin
				rxcfg_reg <= {req.dat[`SSS_B_PORT_EN], req.dat[`SSS_B_NINE_RX],
					req.dat[`SSS_B_SINGLE_RX], req.dat[`SSS_B_CONT_RX]};
			end
			if (wr_tcs) begin
				txcfg_reg <= {req.dat[`SSS_B_CLK_SRC], req.dat[`SSS_B_NINE_TX],
					req.dat[`SSS_B_TX_EN], req.dat[`SSS_B_CLOCKED],
					req.dat[`SSS_B_NINTH_TX]};
			end
			if (wr_rate) begin
				invert_reg <= req.dat[`SSS_B_INVERT];
			end
			if (wr_ien) begin
				ien_reg <= {req.dat[`SSS_B_GLOBAL_IE], req.dat[`SSS_B_PERIPH_IE],
					req.dat[`SSS_B_RX_IE], req.dat[`SSS_B_TX_IE]};
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// pin synchronisers; edges found from the second stage only

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strb_sync_reg <= 2'h0;
			line_sync_reg <= 2'h0;
			strb_last_reg <= 1'b0;
		end else begin
			strb_sync_reg <= {strb_sync_reg[0], serial_strobe_pin};
			line_sync_reg <= {line_sync_reg[0], serial_line_pin_in};
			strb_last_reg <= strb_sync_reg[1];
		end
	end

	// polarity inverts both edge stages, so a flip fakes no edge; mid word it swaps the active edge: change it idle
	wire logic strb_now  = strb_sync_reg[1] ^ invert_reg;
	wire logic strb_prev = strb_last_reg ^ invert_reg;
	wire logic strb_rise = strb_now & ~strb_prev;
	wire logic strb_fall = ~strb_now & strb_prev;
	wire logic line_bit  = line_sync_reg[1];

	////////////////////////////////////////////////////////////////
	// receive shifter: lsb first, sampled on strobe rise

	wire logic [3:0] rx_len = rxcfg_reg.nine_rx ? 4'h9 : 4'h8;
	// no system timing: only strobe edges move it, so sleep is harmless
	wire logic rx_bit  = rx_run & strb_rise;
	wire logic rx_done = rx_bit & (rcnt_reg == rx_len - 4'h1);
	wire logic [8:0] rsh_next = {line_bit, rsh_reg[8:1]};
	// top bit of a nine-bit word lands in the ninth position
	wire logic [8:0] rx_word = rxcfg_reg.nine_rx ? rsh_next
		: {1'b0, rsh_next[8:1]};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsh_reg  <= 9'h000;
			rcnt_reg <= 4'h0;
		end else if (!rx_run) begin
			rcnt_reg <= 4'h0;
		end else if (rx_bit) begin
			rsh_reg  <= rsh_next;
			rcnt_reg <= rx_done ? 4'h0 : rcnt_reg + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// receive fifo and overrun

	wire logic fifo_full  = (cnt_reg == (AW+1)'(DEPTH));
	wire logic fifo_empty = (cnt_reg == '0);
	// a locked overrun keeps new words out until cleared
	wire logic push = rx_done & ~fifo_full & ~ovr_reg;
	wire logic pop  = rd_rxd & ~fifo_empty;
	wire logic rx_flag = ~fifo_empty;
	wire logic [8:0] head = fifo_mem[rd_ptr_reg];
	wire logic ninth_rx = rx_flag & head[8];

	always_ff @(posedge clk) begin
		if (push) begin
			fifo_mem[wr_ptr_reg] <= rx_word;
		end
	end

	// port disable empties the fifo as part of the full reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else if (port_clr) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else begin
			if (push) wr_ptr_reg <= bump(wr_ptr_reg);
			if (pop) rd_ptr_reg <= bump(rd_ptr_reg);
			if (push & ~pop) cnt_reg <= cnt_reg + 1'b1;
			if (pop & ~push) cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// set wins; cleared by dropping receive enable or port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovr_reg <= 1'b0;
		end else if (rx_done & fifo_full) begin
			ovr_reg <= 1'b1;
		end else if (~rxcfg_reg.cont_rx | port_clr) begin
			ovr_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// transmit buffer and shifter: bit changes on strobe fall

	wire logic [3:0] tx_len = txcfg_reg.nine_tx ? 4'h9 : 4'h8;
	wire logic tx_idle = (tx_st_reg == sss_pkg::TXS_IDLE);
	wire logic tx_bit  = tx_run & strb_fall & ~tx_idle;
	wire logic tx_last = tx_bit & (tcnt_reg == tx_len - 4'h1);
	// buffer goes to the shifter when it is free or just emptied
	wire logic tx_load = tbuf_full_reg & tx_run & (tx_idle | tx_last);
	wire logic tx_flag = ~tbuf_full_reg;
	wire logic tx_stop = port_clr | ~slave_mode | ~txcfg_reg.tx_en;

	// a write in the load cycle refills the buffer: set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tbuf_reg      <= 9'h000;
			tbuf_full_reg <= 1'b0;
		end else if (port_clr) begin
			tbuf_full_reg <= 1'b0;
		end else if (wr_txd) begin
			tbuf_reg      <= {txcfg_reg.ninth_tx, req.dat[7:0]};
			tbuf_full_reg <= 1'b1;
		end else if (tx_load) begin
			tbuf_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_reg <= sss_pkg::TXS_IDLE;
			tsh_reg   <= 9'h000;
			tcnt_reg  <= 4'h0;
		end else if (tx_stop) begin
			tx_st_reg <= sss_pkg::TXS_IDLE;
		end else if (tx_load) begin
			tx_st_reg <= sss_pkg::TXS_SHIFT;
			tsh_reg   <= tbuf_reg;
			tcnt_reg  <= 4'h0;
		end else if (tx_last) begin
			tx_st_reg <= sss_pkg::TXS_IDLE;
		end else if (tx_bit) begin
			tsh_reg  <= {1'b0, tsh_reg[8:1]};
			tcnt_reg <= tcnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= tx_run;
		end
	end

	assign serial_line_pin_out = tsh_reg[0];
	assign serial_line_pin_oe  = oe_reg;

	////////////////////////////////////////////////////////////////
	// wake and interrupt

	wire logic rx_irq = rx_flag & ien_reg.rx_ie;
	// transmit needs the peripheral enable even to wake
	wire logic tx_irq = tx_flag & ien_reg.tx_ie & ien_reg.periph_ie;
	wire logic any_irq = rx_irq | tx_irq;

	assign irq_req     = any_irq;
	assign wake_req    = cpu_sleep & any_irq;
	assign vector_take = any_irq & ien_reg.global_ie
		& ien_reg.periph_ie;
	assign vector_addr = `SSS_VECTOR;

	////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero

	wire logic [7:0] v_rcs = fld(rxcfg_reg.port_en, `SSS_B_PORT_EN)
		| fld(rxcfg_reg.nine_rx, `SSS_B_NINE_RX)
		| fld(rxcfg_reg.single_rx, `SSS_B_SINGLE_RX)
		| fld(rxcfg_reg.cont_rx, `SSS_B_CONT_RX)
		| fld(ovr_reg, `SSS_B_OVERRUN)
		| fld(ninth_rx, `SSS_B_NINTH_RX);
	wire logic [7:0] v_tcs = fld(txcfg_reg.clk_src, `SSS_B_CLK_SRC)
		| fld(txcfg_reg.nine_tx, `SSS_B_NINE_TX)
		| fld(txcfg_reg.tx_en, `SSS_B_TX_EN)
		| fld(txcfg_reg.clocked, `SSS_B_CLOCKED)
		| fld(tx_idle, `SSS_B_SH_EMPTY)
		| fld(txcfg_reg.ninth_tx, `SSS_B_NINTH_TX);
	wire logic [7:0] v_rate = fld(rcnt_reg == 4'h0, `SSS_B_RX_IDLE)
		| fld(invert_reg, `SSS_B_INVERT);
	wire logic [7:0] v_ien = fld(ien_reg.global_ie, `SSS_B_GLOBAL_IE)
		| fld(ien_reg.periph_ie, `SSS_B_PERIPH_IE)
		| fld(ien_reg.rx_ie, `SSS_B_RX_IE)
		| fld(ien_reg.tx_ie, `SSS_B_TX_IE)
		| fld(rx_flag, `SSS_B_RX_DONE)
		| fld(tx_flag, `SSS_B_TX_FREE);
	wire logic [7:0] v_rxd = rx_flag ? head[7:0] : 8'h00;
	wire logic [7:0] rd_byte =
		hit(req.adr, `SSS_A_RCS)  ? v_rcs :
		hit(req.adr, `SSS_A_RXD)  ? v_rxd :
		hit(req.adr, `SSS_A_TCS)  ? v_tcs :
		hit(req.adr, `SSS_A_RATE) ? v_rate :
		hit(req.adr, `SSS_A_IEN)  ? v_ien : 8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= acc;
			if (rd) dat_reg <= {24'h00_0000, rd_byte};
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_ack_once;
		wb_ack ##1 !wb_ack;
	endsequence

	sequence s_reload;
		tx_st_reg == sss_pkg::TXS_SHIFT && tcnt_reg == 4'h0 && tx_flag;
	endsequence

	chk_bus_ack_once: assert property (acc |=> s_ack_once)
		else $error("ack not a single cycle after request");
	chk_slave_gate: assert property (!slave_mode |-> !rx_bit && !tx_bit)
		else $error("shifting outside slave mode");
	chk_rx_gate: assert property (!rxcfg_reg.cont_rx |-> !push)
		else $error("word accepted with receive disabled");
	chk_push_count: assert property (push && !pop |=> cnt_reg == $past(cnt_reg) + 1'b1)
		else $error("completed word not counted");
	chk_flag_clear: assert property (pop && cnt_reg == 1 && !push |=> !rx_flag)
		else $error("receive flag stuck after last read");
	chk_overrun_set: assert property (rx_done && fifo_full |=> ovr_reg && !$past(push))
		else $error("overrun not flagged on full buffer");
	chk_overrun_clear: assert property (!rxcfg_reg.cont_rx && !rx_done |=> !ovr_reg)
		else $error("overrun survived receive disable");
	chk_ninth_bit: assert property (push && rxcfg_reg.nine_rx && fifo_empty
		|=> ninth_rx == $past(line_bit))
		else $error("ninth bit not the last received");
	chk_tx_write: assert property (wr_txd && !port_clr |=> !tx_flag)
		else $error("transmit flag not cleared by write");
	chk_tx_reload: assert property (tx_last && tbuf_full_reg && !wr_txd
		&& !tx_stop |=> s_reload)
		else $error("buffer not reloaded into shifter");
	chk_tx_wake: assert property (wake_req && !rx_irq
		|-> ien_reg.tx_ie && ien_reg.periph_ie)
		else $error("transmit wake without its enables");
	chk_rx_wake: assert property (cpu_sleep && rx_flag && ien_reg.rx_ie |-> wake_req)
		else $error("received word did not wake");
	chk_vector_gate: assert property (vector_take
		|-> ien_reg.global_ie && ien_reg.periph_ie)
		else $error("vector without global enables");
endmodule

//--- verification/sss_master_model.sv
// sss_master_model: external shift-clock master facing the slave port
// assumes: the bench resolves the line from the port's output enable
`timescale 1ns/1ns
module sss_master_model (
	// serial pins
	input  wire logic line_pin,
	output logic      strobe_pin,
	output logic      line_drv
);
	////////////////////////////////////////////////////////////////////////////////
	// idle: strobe stands at its idle level between frames, line released
	logic pol;
	initial begin
		pol = 1'b0;
		strobe_pin = 1'b0;
		line_drv = 1'b1;
	end
	// idle level of the strobe; the slave's polarity bit must agree with it
	task automatic idle(input logic p);
		pol = p;
		strobe_pin = p;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// one frame of n bits, lsb first; odd start offset keeps phase unrelated to clk
	task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
		rx = 9'h000;
		#37;
		for (int i = 0; i < n; i++) begin
			line_drv = tx[i];
			#400 strobe_pin = ~pol;
			rx[i] = line_pin;
			#400 strobe_pin = pol;
		end
		// a released line shows the inverse so a stale bit cannot pass
		line_drv = ~line_drv;
	endtask
endmodule

//--- verification/sss_slave_port_tb_top.sv
// sss_slave_port_tb_top: self-checking bench for the serial slave port
// assumes: register map of sss_regs.svh, master model on the serial pins
`timescale 1ns/1ns
`include "sss_regs.svh"
module sss_slave_port_tb_top;
	////////////////////////////////////////////////////////////////////////////////
	// signals
	logic               clk;
	logic               rst_n;
	logic               act;
	sss_pkg::sss_wbreq_t req;
	logic               cpu_sleep;
	logic        [31:0] wb_dat_rd;
	logic               wb_ack;
	logic               strobe;
	logic               drv;
	logic               line_out;
	logic               line_oe;
	logic               wake_req;
	logic               irq_req;
	logic               vector_take;
	logic        [15:0] vector_addr;
	wire                line_w;
	logic        [31:0] q;
	logic         [8:0] rx;
	int                 err_count;
	int                 tests_run;
	typedef struct {logic [7:0] adr; logic w; logic [7:0] d; logic [7:0] e;} sss_row_t;
	sss_row_t rows [11] = '{
		'{`SSS_A_RCS, 1'b0, 8'h00, 8'h00}, '{`SSS_A_RXD, 1'b0, 8'h00, 8'h00},
		'{`SSS_A_TCS, 1'b0, 8'h00, 8'h02}, '{`SSS_A_RATE, 1'b0, 8'h00, 8'h40},
		'{`SSS_A_TXD, 1'b0, 8'h00, 8'h00}, '{`SSS_A_IEN, 1'b0, 8'h00, 8'h01},
		'{8'h18, 1'b1, 8'hFF, 8'h00}, '{`SSS_A_RATE, 1'b1, 8'hFF, 8'h50},
		'{`SSS_A_RATE, 1'b1, 8'h00, 8'h40}, '{`SSS_A_TCS, 1'b1, 8'hFF, 8'hF3},
		'{`SSS_A_TCS, 1'b1, 8'h30, 8'h32}};
	////////////////////////////////////////////////////////////////////////////////
	// clock, line resolution, design and far side
	initial clk = 1'b0;
	always #50 clk = ~clk;
	assign line_w = line_oe ? line_out : drv;
	sss_slave_port u_dut (
		.clk(clk), .rst_n(rst_n), .wb_cyc(act), .wb_stb(act), .wb_we(req.we),
		.wb_adr(req.adr), .wb_sel(req.sel), .wb_dat_wr(req.dat), .wb_dat_rd(wb_dat_rd),
		.wb_ack(wb_ack), .cpu_sleep(cpu_sleep), .serial_strobe_pin(strobe),
		.serial_line_pin_in(line_w), .serial_line_pin_out(line_out),
		.serial_line_pin_oe(line_oe), .wake_req(wake_req), .irq_req(irq_req),
		.vector_take(vector_take), .vector_addr(vector_addr)
	);
	sss_master_model u_mst (.line_pin(line_w), .strobe_pin(strobe), .line_drv(drv));
	////////////////////////////////////////////////////////////////////////////////
	// compare, bus cycle and link helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic flag(input string n, input logic e, input logic s);
		chk(n, {31'h0, e}, {31'h0, s});
	endtask
	// classic cycle: hold everything until ack is sampled, take data there
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk);
		act <= 1'b1;
		req <= '{a, w, 4'hF, {24'h000000, d}};
		do begin
			@(posedge clk);
			t++;
		end while (wb_ack !== 1'b1 && t < 40);
		q = wb_dat_rd;
		act <= 1'b0;
		flag("wb_ack", 1'b1, wb_ack);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		wb(a, 1'b0, 8'h00);
		chk(n, {24'h000000, e}, q);
	endtask
	// edge detection lags the pin by up to two clocks, plus one to land
	task automatic send(input logic [8:0] v, input int n);
		u_mst.xfer(v, n, rx);
		repeat (6) @(posedge clk);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs well under a tenth of this
	initial begin
		#3000000;
		flag("watchdog", 1'b0, 1'b1);
		results();
	end
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		err_count = 0;
		tests_run = 0;
		act = 1'b0;
		req = '0;
		cpu_sleep = 1'b0;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		flag("irq_rst", 1'b0, irq_req);
		flag("oe_rst", 1'b0, line_oe);
		chk("vector_addr", 32'h4, {16'h0, vector_addr});
		foreach (rows[i]) begin
			if (rows[i].w)
				wb(rows[i].adr, 1'b1, rows[i].d);
			rd(rows[i].adr, rows[i].e, "row");
		end
		// master clock source: no shifting while asleep
		wb(`SSS_A_TCS, 1'b1, 8'h90);
		wb(`SSS_A_RCS, 1'b1, 8'h90);
		@(posedge clk) cpu_sleep <= 1'b1;
		send(9'h0A5, 8);
		rd(`SSS_A_IEN, 8'h01, "rx_master_sleep");
		// slave reception in sleep, wake and vector
		wb(`SSS_A_TCS, 1'b1, 8'h10);
		wb(`SSS_A_IEN, 1'b1, 8'h20);
		send(9'h0A5, 8);
		flag("wake_rx", 1'b1, wake_req);
		flag("irq_rx", 1'b1, irq_req);
		flag("vector_rx", 1'b0, vector_take);
		rd(`SSS_A_IEN, 8'h23, "rx_flag");
		wb(`SSS_A_IEN, 1'b1, 8'hE0);
		flag("vector_on", 1'b1, vector_take);
		rd(`SSS_A_RXD, 8'hA5, "rx_data");
		rd(`SSS_A_IEN, 8'hE1, "rx_flag_clr");
		flag("wake_off", 1'b0, wake_req);
		// single receive enable is ignored, continuous enable gates
		wb(`SSS_A_RCS, 1'b1, 8'hB0);
		send(9'h03C, 8);
		rd(`SSS_A_RXD, 8'h3C, "rx_single_set");
		wb(`SSS_A_RCS, 1'b1, 8'hA0);
		send(9'h0C3, 8);
		rd(`SSS_A_RXD, 8'h00, "rx_gated");
		// nine-bit word
		wb(`SSS_A_RCS, 1'b1, 8'hD0);
		send(9'h15A, 9);
		rd(`SSS_A_RCS, 8'hD1, "ninth_bit");
		rd(`SSS_A_RXD, 8'h5A, "nine_data");
		// overrun on a full buffer, words kept out until cleared
		wb(`SSS_A_RCS, 1'b1, 8'h90);
		send(9'h011, 8);
		send(9'h022, 8);
		send(9'h033, 8);
		rd(`SSS_A_RCS, 8'h92, "overrun");
		rd(`SSS_A_RXD, 8'h11, "ovr_first");
		send(9'h044, 8);
		rd(`SSS_A_RXD, 8'h22, "ovr_second");
		rd(`SSS_A_RXD, 8'h00, "ovr_dropped");
		wb(`SSS_A_RCS, 1'b1, 8'h80);
		rd(`SSS_A_RCS, 8'h80, "ovr_clear");
		// inverted strobe: idle high at the pin, same word with receive on
		wb(`SSS_A_RATE, 1'b1, 8'h10);
		u_mst.idle(1'b1);
		wb(`SSS_A_RCS, 1'b1, 8'h90);
		send(9'h069, 8);
		rd(`SSS_A_RXD, 8'h69, "rx_invert");
		// receive off before the strobe returns low, or that edge samples a bit
		wb(`SSS_A_RCS, 1'b1, 8'h80);
		u_mst.idle(1'b0);
		wb(`SSS_A_RATE, 1'b1, 8'h00);
		// slave transmission in sleep with a queued second word
		wb(`SSS_A_TCS, 1'b1, 8'h30);
		wb(`SSS_A_IEN, 1'b1, 8'h10);
		flag("tx_wake_noperiph", 1'b0, wake_req);
		wb(`SSS_A_IEN, 1'b1, 8'h50);
		wb(`SSS_A_TXD, 1'b1, 8'h96);
		wb(`SSS_A_TXD, 1'b1, 8'h4B);
		flag("tx_oe", 1'b1, line_oe);
		flag("tx_wake_full", 1'b0, wake_req);
		send(9'h000, 8);
		chk("tx_first", 32'h96, {23'h0, rx});
		flag("tx_wake_reload", 1'b1, wake_req);
		wb(`SSS_A_TXD, 1'b1, 8'hC3);
		rd(`SSS_A_IEN, 8'h50, "tx_refill");
		send(9'h000, 8);
		chk("tx_second", 32'h4B, {23'h0, rx});
		send(9'h000, 8);
		chk("tx_third", 32'hC3, {23'h0, rx});
		// nine-bit word: ninth bit comes from the transmit control register
		wb(`SSS_A_TCS, 1'b1, 8'h71);
		wb(`SSS_A_TXD, 1'b1, 8'h5A);
		send(9'h000, 9);
		chk("tx_nine", 32'h15A, {23'h0, rx});
		// reset in mid-run brings back the reset state of the registers
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		flag("oe_rst2", 1'b0, line_oe);
		rd(`SSS_A_TCS, 8'h02, "tcs_rst2");
		rd(`SSS_A_IEN, 8'h01, "ien_rst2");
		flag("wake_rst2", 1'b0, wake_req);
		results();
	end
endmodule
